//--- rspc_pkg.sv
package rspc_pkg;

    // Register map of the host port (word addresses)
    localparam logic [3:0] RSPC_ADDR_CFG    = 4'h0;
    localparam logic [3:0] RSPC_ADDR_OPSTAT = 4'h1;
    localparam logic [3:0] RSPC_ADDR_STATUS = 4'h2;
    localparam logic [3:0] RSPC_ADDR_INTMSK = 4'h3;
    localparam logic [3:0] RSPC_ADDR_EVENT  = 4'h4;
    localparam logic [3:0] RSPC_ADDR_DONE   = 4'h5;

    // Configuration register fields
    localparam int RSPC_CFG_SOFT_RST_BIT  = 0;
    localparam int RSPC_CFG_START_EXEC_BIT  = 1;
    localparam int RSPC_CFG_STYLE = 2;
    localparam int RSPC_CFG_INHA  = 3;
    localparam int RSPC_CFG_INHB  = 4;
    localparam logic [15:0] RSPC_CFG_RST = 16'h0000;

    // Operational status fields: address 4:0, parity 5, write protect 6
    localparam int RSPC_OP_PAR  = 5;
    localparam int RSPC_OP_LOCK = 6;

    // Interrupt status bits
    localparam int RSPC_EV_READY = 0;
    localparam int RSPC_EV_COPY  = 1;
    localparam int RSPC_EV_PARE  = 2;
    localparam int RSPC_EV_W     = 3;

    // Auto-initialization ranges
    localparam logic [14:0] RSPC_RANGE_FULL  = 15'h7fff;
    localparam logic [14:0] RSPC_RANGE_SMALL = 15'h03ff;

    // Interrupt pulse width
    localparam int RSPC_PULSE_NS  = 500;
    localparam int RSPC_CLK_NS    = 50;
    localparam int RSPC_PULSE_CYC = (RSPC_PULSE_NS + RSPC_CLK_NS - 1) / RSPC_CLK_NS;

    typedef enum logic [2:0] {
        RSPC_IDLE,
        RSPC_MEMTEST,
        RSPC_AUTOINIT,
        RSPC_READY,
        RSPC_COPY
    } rspc_state_t;

endpackage : rspc_pkg

//--- rspc_if.sv
interface rspc_if;
    logic        start;
    logic [14:0] last_addr;
    logic        busy;
    logic        done;

    modport master (output start, output last_addr, input busy, input done);
    modport worker (input start, input last_addr, output busy, output done);
endinterface : rspc_if

//--- rspc_walker.sv
// Address walker standing in for one RAM or EEPROM pass
module rspc_walker
    import rspc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic soft_clr,
    rspc_if.worker    wk
);

    logic [14:0] addr_r;
    logic        busy_r;
    logic        done_r;

    assign wk.busy = busy_r;
    assign wk.done = done_r;

    // One address per clock up to the requested last address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= 15'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (soft_clr) begin
            addr_r <= 15'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (wk.start && !busy_r) begin
                addr_r <= 15'h0000;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (addr_r == wk.last_addr) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end else begin
                    addr_r <= addr_r + 15'h0001;
                end
            end
        end
    end

endmodule : rspc_walker

//--- rspc_top.sv
// What this block does
// - Both interrupt pins hw_irq_n and msg_irq_n are active low, pulse or level chosen by a config bit; irq is active high.
// - Master reset pin low resets; writing the software reset bit also resets.
// - Memory test over all RAM after reset unless test-disable input is high.
// - Auto-init enable high at reset release copies EEPROM into registers and RAM.
// - Range-select picks 0x7FFF or 0x03FF end; ignored without auto-init.
// - Copy input starts writing registers and tables out to the EEPROM.
// - Address straps and parity latched into operational status at reset release.
// - Latched write-protect bit blocks host writes to address and parity.
// - Each bus transmit inhibit is pin OR config bit.
// - Ready low during init or test; execution starts once start bit set.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
module rspc_top
    import rspc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        master_rst_n,
    input  wire logic        ram_test_disable,
    input  wire logic        auto_init_en,
    input  wire logic        init_range_small,
    input  wire logic        eeprom_copy_req,
    input  wire logic [4:0]  term_addr_strap,
    input  wire logic        term_addr_parity,
    input  wire logic        addr_lock,
    input  wire logic        tx_inhibit_a,
    input  wire logic        tx_inhibit_b,
    input  wire logic        hw_event,
    input  wire logic        msg_event,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    output logic             hw_irq_n,
    output logic             msg_irq_n,
    output logic             ready,
    output logic             exec_en,
    output logic             tx_dis_a,
    output logic             tx_dis_b,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, change counts when stages 2 and 3 agree

    localparam int NPIN = 13;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_r;
    logic [NPIN-1:0] s2_r;
    logic [NPIN-1:0] s3_r;
    logic [NPIN-1:0] pin_r;

    assign pin_raw = {master_rst_n, ram_test_disable, auto_init_en, init_range_small,
                      eeprom_copy_req, term_addr_strap, term_addr_parity, addr_lock,
                      tx_inhibit_a};

    // Pins reset to their pulled idle levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r  <= 13'h1000;
            s2_r  <= 13'h1000;
            s3_r  <= 13'h1000;
            pin_r <= 13'h1000;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < NPIN; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    pin_r[i] <= s3_r[i];
                end
            end
        end
    end

    logic inhb_s1_r, inhb_s2_r, inhb_s3_r, inhb_r;

    // Bus B inhibit pin, same filter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inhb_s1_r <= 1'b0;
            inhb_s2_r <= 1'b0;
            inhb_s3_r <= 1'b0;
            inhb_r    <= 1'b0;
        end else begin
            inhb_s1_r <= tx_inhibit_b;
            inhb_s2_r <= inhb_s1_r;
            inhb_s3_r <= inhb_s2_r;
            if (inhb_s2_r == inhb_s3_r) begin
                inhb_r <= inhb_s3_r;
            end
        end
    end

    logic       mr_n_q;
    logic       mtoff_q, aen_q, small_q, copy_q, par_q, lock_q, inha_q;
    logic [4:0] rta_q;
    assign {mr_n_q, mtoff_q, aen_q, small_q, copy_q, rta_q, par_q, lock_q, inha_q} = pin_r;

    ////////////////////////////////////////////////////////////////////////////
    // Reset sources and edge detection

    logic [15:0] cfg_r;
    logic        mr_n_d_r;
    logic        copy_d_r;
    logic        mr_rise;
    logic        copy_rise;
    logic        soft_rst;

    assign mr_rise   = mr_n_q && !mr_n_d_r;
    assign copy_rise = copy_q && !copy_d_r;
    assign soft_rst  = !mr_n_q || (reg_wr && reg_addr == RSPC_ADDR_CFG
                                   && reg_wdata[RSPC_CFG_SOFT_RST_BIT]);

    // Edge history registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mr_n_d_r <= 1'b1;
            copy_d_r <= 1'b0;
        end else begin
            mr_n_d_r <= mr_n_q;
            copy_d_r <= copy_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    rspc_state_t state_r;
    logic        aen_lat_r;
    logic        small_lat_r;
    logic        mtoff_lat_r;
    logic        copy_pend_r;
    rspc_if      wk_if ();
    logic        wk_start;
    logic [14:0] wk_last;

    assign wk_if.start     = wk_start;
    assign wk_if.last_addr = wk_last;

    rspc_walker u_walker (
        .clk      (clk),
        .rst_n    (rst_n),
        .soft_clr (soft_rst),
        .wk       (wk_if.worker)
    );

    // Straps caught by a clocked process at the reset release edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aen_lat_r   <= 1'b0;
            small_lat_r <= 1'b0;
            mtoff_lat_r <= 1'b0;
        end else if (mr_rise) begin
            aen_lat_r   <= aen_q;
            small_lat_r <= aen_q && small_q;
            mtoff_lat_r <= mtoff_q;
        end
    end

    // Range of the auto-init pass
    assign wk_last  = (state_r == RSPC_AUTOINIT && small_lat_r) ? RSPC_RANGE_SMALL
                                                                 : RSPC_RANGE_FULL;
    assign wk_start = (state_r == RSPC_MEMTEST || state_r == RSPC_AUTOINIT
                       || state_r == RSPC_COPY) && !wk_if.busy && !wk_if.done;

    // Main sequence: memory test, then auto-init, then ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= RSPC_IDLE;
        end else if (!mr_n_q) begin
            state_r <= RSPC_IDLE;
        end else begin
            unique case (state_r)
                RSPC_IDLE: begin
                    if (mr_rise || mr_n_d_r) begin
                        if (!mtoff_q) begin
                            state_r <= RSPC_MEMTEST;
                        end else if (aen_q) begin
                            state_r <= RSPC_AUTOINIT;
                        end else begin
                            state_r <= RSPC_READY;
                        end
                    end
                end
                RSPC_MEMTEST: begin
                    if (wk_if.done) begin
                        state_r <= aen_lat_r ? RSPC_AUTOINIT : RSPC_READY;
                    end
                end
                RSPC_AUTOINIT: begin
                    if (wk_if.done) begin
                        state_r <= RSPC_READY;
                    end
                end
                RSPC_READY: begin
                    if (copy_pend_r) begin
                        state_r <= RSPC_COPY;
                    end
                end
                RSPC_COPY: begin
                    if (wk_if.done) begin
                        state_r <= RSPC_READY;
                    end
                end
            endcase
        end
    end

    // A copy request that arrives during init waits for ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            copy_pend_r <= 1'b0;
        end else if (!mr_n_q) begin
            copy_pend_r <= 1'b0;
        end else if (copy_rise) begin
            copy_pend_r <= 1'b1;
        end else if (state_r == RSPC_COPY) begin
            copy_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [6:0] opstat_r;
    logic [3:0] evt_r;
    logic [3:0] mask_r;
    logic [3:0] evt_set;
    logic       parity_bad;
    logic       host_ok;

    // Host access is illegal while ready is low
    assign host_ok    = (state_r == RSPC_READY);
    assign parity_bad = ~^{rta_q, par_q};

    // Configuration register; software reset clears it and self-clears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= RSPC_CFG_RST;
        end else if (soft_rst) begin
            cfg_r <= RSPC_CFG_RST;
        end else if (reg_wr && host_ok && reg_addr == RSPC_ADDR_CFG) begin
            cfg_r <= reg_wdata;
        end
    end

    // Operational status: straps latched on reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opstat_r <= 7'h00;
        end else if (mr_rise) begin
            opstat_r <= {lock_q, par_q, rta_q};
        end else if (reg_wr && host_ok && reg_addr == RSPC_ADDR_OPSTAT
                     && !opstat_r[RSPC_OP_LOCK]) begin
            opstat_r[RSPC_OP_PAR:0] <= reg_wdata[RSPC_OP_PAR:0];
        end
    end

    assign evt_set = {1'b0, mr_rise && parity_bad,
                      state_r == RSPC_COPY && wk_if.done,
                      state_r != RSPC_READY && state_r != RSPC_COPY
                      && state_r != RSPC_IDLE && wk_if.done};

    // Sticky events, cleared by reading; a new event wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_r <= 4'h0;
        end else if (reg_rd && reg_addr == RSPC_ADDR_EVENT) begin
            evt_r <= evt_set;
        end else begin
            evt_r <= evt_r | evt_set;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= 4'h0;
        end else if (reg_wr && reg_addr == RSPC_ADDR_INTMSK) begin
            mask_r <= reg_wdata[3:0];
        end
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                RSPC_ADDR_CFG:    reg_rdata <= cfg_r;
                RSPC_ADDR_OPSTAT: reg_rdata <= {9'h000, opstat_r};
                RSPC_ADDR_STATUS: reg_rdata <= {10'h000, mtoff_lat_r, small_lat_r,
                                                aen_lat_r, copy_pend_r, host_ok, exec_en};
                RSPC_ADDR_INTMSK: reg_rdata <= {12'h000, mask_r};
                RSPC_ADDR_EVENT:  reg_rdata <= {12'h000, evt_r};
                default:          reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Ready, execution and transmit inhibits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready    <= 1'b0;
            exec_en  <= 1'b0;
            tx_dis_a <= 1'b0;
            tx_dis_b <= 1'b0;
            irq      <= 1'b0;
        end else begin
            ready    <= host_ok || state_r == RSPC_COPY;
            exec_en  <= host_ok && cfg_r[RSPC_CFG_START_EXEC_BIT];
            tx_dis_a <= inha_q || cfg_r[RSPC_CFG_INHA];
            tx_dis_b <= inhb_r || cfg_r[RSPC_CFG_INHB];
            irq      <= |(evt_r & mask_r);
        end
    end

    logic [3:0] hw_cnt_r;
    logic [3:0] msg_cnt_r;

    // Active-low interrupt pins: pulse stretched to a fixed width, or level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_cnt_r  <= 4'h0;
            msg_cnt_r <= 4'h0;
            hw_irq_n  <= 1'b1;
            msg_irq_n <= 1'b1;
        end else if (cfg_r[RSPC_CFG_STYLE]) begin
            hw_cnt_r  <= 4'h0;
            msg_cnt_r <= 4'h0;
            hw_irq_n  <= !hw_event;
            msg_irq_n <= !msg_event;
        end else begin
            hw_cnt_r  <= hw_event ? 4'(RSPC_PULSE_CYC) : (hw_cnt_r != 4'h0 ? hw_cnt_r - 4'h1 : 4'h0);
            msg_cnt_r <= msg_event ? 4'(RSPC_PULSE_CYC) : (msg_cnt_r != 4'h0 ? msg_cnt_r - 4'h1 : 4'h0);
            hw_irq_n  <= !(hw_event || hw_cnt_r > 4'h1);
            msg_irq_n <= !(msg_event || msg_cnt_r > 4'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_inh_a;
        @(posedge clk) disable iff (!rst_n)
        (inha_q || cfg_r[RSPC_CFG_INHA]) |=> tx_dis_a;
    endproperty
    a_inh_a: assert property (p_inh_a) else $error("bus A inhibit missed");

    property p_inh_b;
        @(posedge clk) disable iff (!rst_n)
        (!inhb_r && !cfg_r[RSPC_CFG_INHB]) |=> !tx_dis_b;
    endproperty
    a_inh_b: assert property (p_inh_b) else $error("bus B inhibit stuck");

    property p_latch;
        @(posedge clk) disable iff (!rst_n)
        mr_rise |=> opstat_r[4:0] == $past(rta_q);
    endproperty
    a_latch: assert property (p_latch) else $error("address not latched");

    property p_lock;
        @(posedge clk) disable iff (!rst_n)
        (opstat_r[RSPC_OP_LOCK] && !mr_rise) |=> $stable(opstat_r);
    endproperty
    a_lock: assert property (p_lock) else $error("locked address changed");

    property p_ready;
        @(posedge clk) disable iff (!rst_n)
        (state_r == RSPC_MEMTEST || state_r == RSPC_AUTOINIT) |=> !ready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready high during init");

    property p_exec;
        @(posedge clk) disable iff (!rst_n)
        exec_en |-> $past(cfg_r[RSPC_CFG_START_EXEC_BIT]) && $past(host_ok);
    endproperty
    a_exec: assert property (p_exec) else $error("exec without start bit");

    property p_copy_once;
        @(posedge clk) disable iff (!rst_n)
        (copy_q && copy_d_r && !copy_pend_r) |=> !copy_pend_r;
    endproperty
    a_copy_once: assert property (p_copy_once) else $error("held copy retriggered");

    property p_level;
        @(posedge clk) disable iff (!rst_n)
        (cfg_r[RSPC_CFG_STYLE] && hw_event) |=> !hw_irq_n;
    endproperty
    a_level: assert property (p_level) else $error("level irq missing");

    property p_soft_rst_bit;
        @(posedge clk) disable iff (!rst_n)
        soft_rst |=> cfg_r == RSPC_CFG_RST;
    endproperty
    a_soft_rst_bit: assert property (p_soft_rst_bit) else $error("soft reset ignored");

    property p_skip;
        @(posedge clk) disable iff (!rst_n)
        (state_r == RSPC_IDLE && mr_rise && mtoff_q) |=> state_r != RSPC_MEMTEST;
    endproperty
    a_skip: assert property (p_skip) else $error("test not skipped");

endmodule : rspc_top

//--- rspc_host_model.sv
// Host processor and strap pins facing the block
module rspc_host_model
    import rspc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        ready,
    input  wire logic [15:0] reg_rdata,
    output logic [3:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             master_rst_n,
    output logic [4:0]       term_addr_strap,
    output logic             term_addr_parity,
    output logic             addr_lock,
    output logic             ram_test_disable,
    output logic             auto_init_en,
    output logic             init_range_small
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////
    // Quiet bus and released reset at power up
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {term_addr_strap, term_addr_parity, addr_lock} = '0;
        {ram_test_disable, auto_init_en, init_range_small} = '0;
        master_rst_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // Straps settle while reset is low, held after release
    task automatic boot(input logic [4:0] a, input logic lk, input logic td, input logic ae, input logic sm);
        @(posedge clk);
        master_rst_n     <= 1'b0;
        term_addr_strap  <= a;
        term_addr_parity <= ~(^a);
        addr_lock        <= lk;
        ram_test_disable <= td;
        auto_init_en     <= ae;
        init_range_small <= sm;
        repeat (8) @(posedge clk);
        master_rst_n <= 1'b1;
    endtask : boot

    // Bounded so a dead ready cannot hang the host
    task automatic wait_rdy;
        for (int i = 0; i < 40000 && ready !== 1'b1; i++) @(posedge clk);
    endtask : wait_rdy

    // Idle bus shows inverted values, not stale ones
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        wait_rdy();
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        wait_rdy();
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
endmodule : rspc_host_model

//--- tb_top.sv
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rspc_pkg::*;

    logic clk, rst_n, master_rst_n, ram_test_disable, auto_init_en, init_range_small;
    logic eeprom_copy_req, term_addr_parity, addr_lock, tx_inhibit_a, tx_inhibit_b;
    logic hw_event, msg_event, reg_wr, reg_rd, hw_irq_n, msg_irq_n, ready, exec_en;
    logic tx_dis_a, tx_dis_b, irq;
    logic [4:0]  term_addr_strap;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    int          fails, check_count;

    rspc_top dut (.clk(clk), .rst_n(rst_n), .master_rst_n(master_rst_n),
        .ram_test_disable(ram_test_disable), .auto_init_en(auto_init_en),
        .init_range_small(init_range_small), .eeprom_copy_req(eeprom_copy_req),
        .term_addr_strap(term_addr_strap), .term_addr_parity(term_addr_parity),
        .addr_lock(addr_lock), .tx_inhibit_a(tx_inhibit_a), .tx_inhibit_b(tx_inhibit_b),
        .hw_event(hw_event), .msg_event(msg_event), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_irq_n(hw_irq_n),
        .msg_irq_n(msg_irq_n), .ready(ready), .exec_en(exec_en), .tx_dis_a(tx_dis_a),
        .tx_dis_b(tx_dis_b), .irq(irq));

    rspc_host_model host (.clk(clk), .ready(ready), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .master_rst_n(master_rst_n),
        .term_addr_strap(term_addr_strap), .term_addr_parity(term_addr_parity),
        .addr_lock(addr_lock), .ram_test_disable(ram_test_disable),
        .auto_init_en(auto_init_en), .init_range_small(init_range_small));

    ////////////////////////////////////////////////////////////////
    // 20 MHz core clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic final_report;
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // Reset pulse, then cycles until ready, bounded
    task automatic boot_wait(input logic [4:0] a, input logic lk, input logic td, input logic ae,
                             input logic sm, output int n);
        host.boot(a, lk, td, ae, sm);
        n = 0;
        while (ready !== 1'b1 && n < 40000) begin
            @(posedge clk);
            n++;
        end
    endtask : boot_wait

    ////////////////////////////////////////////////////////////////
    // Short init, test skipped, straps locked
    task automatic t_boot_small;
        int n;
        logic [15:0] d;
        boot_wait(5'h13, 1'b1, 1'b1, 1'b1, 1'b1, n);
        `CHK(n >= 1020 && n <= 1044, 1'b1);
        host.rd(RSPC_ADDR_OPSTAT, d);
        `CHK(d & 16'h007f, 16'h0053);
        host.wr(RSPC_ADDR_OPSTAT, 16'h0001);
        host.rd(RSPC_ADDR_OPSTAT, d);
        `CHK(d & 16'h007f, 16'h0053);
        host.rd(RSPC_ADDR_STATUS, d);
        `CHK(d & 16'h003f, 16'h003a);
        host.rd(RSPC_ADDR_EVENT, d);
        `CHK(d & 16'h0007, 16'h0001);
        host.rd(RSPC_ADDR_EVENT, d);
        `CHK(d & 16'h0007, 16'h0000);
    endtask : t_boot_small

    // Pin and config bit mixed so a swap of buses shows
    task automatic t_inhibit;
        logic [15:0] w;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            w = 16'h0000;
            w[RSPC_CFG_INHA] = i[1];
            w[RSPC_CFG_INHB] = i[0];
            tx_inhibit_a <= i[0];
            tx_inhibit_b <= i[2];
            host.wr(RSPC_ADDR_CFG, w);
            repeat (6) @(posedge clk);
            `CHK(tx_dis_a, logic'(i[0] | i[1]));
            `CHK(tx_dis_b, logic'(i[2] | i[0]));
        end
        tx_inhibit_a <= 1'b0;
        tx_inhibit_b <= 1'b0;
    endtask : t_inhibit

    // Pulse width counted, then level style held and dropped
    task automatic t_irq_style;
        int lo;
        logic [15:0] d;
        host.wr(RSPC_ADDR_CFG, 16'h0000);
        @(posedge clk);
        hw_event <= 1'b1;
        @(posedge clk);
        hw_event <= 1'b0;
        lo = 0;
        repeat (30) begin
            @(negedge clk);
            lo += int'(hw_irq_n === 1'b0);
        end
        `CHK(lo, RSPC_PULSE_CYC);
        host.wr(RSPC_ADDR_CFG, 16'h0001 << RSPC_CFG_STYLE);
        @(posedge clk);
        hw_event  <= 1'b1;
        msg_event <= 1'b1;
        repeat (20) @(posedge clk);
        `CHK(msg_irq_n, 1'b0);
        `CHK(hw_irq_n, 1'b0);
        hw_event  <= 1'b0;
        msg_event <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK(msg_irq_n, 1'b1);
        `CHK(hw_irq_n, 1'b1);
        host.rd(RSPC_ADDR_EVENT, d);
    endtask : t_irq_style

    // Start bit, then soft reset clears config but keeps ready
    task automatic t_exec;
        logic [15:0] d;
        host.wr(RSPC_ADDR_CFG, 16'h0001 << RSPC_CFG_START_EXEC_BIT);
        repeat (4) @(posedge clk);
        `CHK(exec_en, 1'b1);
        host.wr(RSPC_ADDR_CFG, 16'h0001 << RSPC_CFG_SOFT_RST_BIT);
        repeat (4) @(posedge clk);
        `CHK(exec_en, 1'b0);
        host.rd(RSPC_ADDR_CFG, d);
        `CHK(d, RSPC_CFG_RST);
        `CHK(ready, 1'b1);
    endtask : t_exec

    // Copy held high: one pass, sticky event, mask, clear on read
    task automatic t_copy;
        int n;
        logic [15:0] d;
        host.wr(RSPC_ADDR_INTMSK, 16'h0001 << RSPC_EV_COPY);
        @(posedge clk);
        eeprom_copy_req <= 1'b1;
        repeat (8) @(posedge clk);
        host.rd(RSPC_ADDR_STATUS, d);
        `CHK(d & 16'h0006, 16'h0000);
        n = 0;
        while (irq !== 1'b1 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        `CHK(n >= 32740 && n <= 32790, 1'b1);
        repeat (10) @(posedge clk);
        host.rd(RSPC_ADDR_STATUS, d);
        `CHK(d[2], 1'b0);
        host.wr(RSPC_ADDR_INTMSK, 16'h0000);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0);
        host.wr(RSPC_ADDR_INTMSK, 16'h0001 << RSPC_EV_COPY);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1);
        host.rd(RSPC_ADDR_EVENT, d);
        `CHK(d & 16'h0007, 16'h0002);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0);
        eeprom_copy_req <= 1'b0;
    endtask : t_copy

    // Full memory test, init off so range pin must be ignored
    task automatic t_boot_full;
        int n;
        logic [15:0] d;
        boot_wait(5'h0c, 1'b0, 1'b0, 1'b0, 1'b1, n);
        `CHK(n >= 32764 && n <= 32790, 1'b1);
        host.rd(RSPC_ADDR_STATUS, d);
        `CHK(d & 16'h003f, 16'h0002);
        host.rd(RSPC_ADDR_OPSTAT, d);
        `CHK(d & 16'h007f, 16'h002c);
        host.wr(RSPC_ADDR_OPSTAT, 16'h0015);
        host.rd(RSPC_ADDR_OPSTAT, d);
        `CHK(d & 16'h003f, 16'h0015);
    endtask : t_boot_full

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fails = 0;
        check_count = 0;
        rst_n = 1'b0;
        {eeprom_copy_req, tx_inhibit_a, tx_inhibit_b, hw_event, msg_event} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_boot_small();
        t_inhibit();
        t_irq_style();
        t_exec();
        t_copy();
        t_boot_full();
        final_report();
    end

    // Watchdog, about 80k cycles against roughly 67k expected
    initial begin
        #(80000 * 50);
        fails++;
        final_report();
    end
endmodule : tb_top
